/* File: common/ilbd_pkg.sv */
// Purpose: Shared constants and types of the inband loop code detector.
// Assumes: One core clock; received line bits arrive as qualified samples.
// Notes:   Register byte address is four times the register index.

package ilbd_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ************************************************************
  // Register indices and byte addresses
  // ************************************************************
  localparam logic [7:0] IDX_CONFIG    = 8'h76;
  localparam logic [7:0] IDX_STATUS    = 8'h77;
  localparam logic [7:0] IDX_UP_PAT    = 8'h78;
  localparam logic [7:0] IDX_DOWN_PAT  = 8'h79;
  localparam logic [7:0] IDX_IRQ_EN    = 8'h7A;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h7B;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG    = ADDR_W'({IDX_CONFIG, 2'h0});
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = ADDR_W'({IDX_STATUS, 2'h0});
  localparam logic [ADDR_W-1:0] ADDR_UP_PAT    = ADDR_W'({IDX_UP_PAT, 2'h0});
  localparam logic [ADDR_W-1:0] ADDR_DOWN_PAT  = ADDR_W'({IDX_DOWN_PAT, 2'h0});
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN    = ADDR_W'({IDX_IRQ_EN, 2'h0});
  localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS = ADDR_W'({IDX_IRQ_FLAGS, 2'h0});

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int unsigned CFG_UP_SEL_LSB   = 0;
  localparam int unsigned CFG_DOWN_SEL_LSB = 2;
  localparam int unsigned CFG_SKIP_BIT     = 4;
  localparam int unsigned UP_BIT           = 1;
  localparam int unsigned DOWN_BIT         = 0;
  localparam logic [4:0] CONFIG_RST   = 5'h04;
  localparam logic [7:0] UP_PAT_RST   = 8'h08;
  localparam logic [7:0] DOWN_PAT_RST = 8'h24;
  localparam logic [1:0] IRQ_EN_RST   = 2'h0;
  localparam logic [1:0] FLAGS_RST    = 2'h0;

  // ************************************************************
  // Timing and thresholds
  // ************************************************************
  localparam real         PERIOD_MS        = 39.8;
  localparam real         LINE_RATE_HZ     = 1544000.0;
  localparam int unsigned PERIOD_BITS_DFLT = int'($floor(PERIOD_MS * LINE_RATE_HZ / 1000.0));
  localparam int unsigned ERR_W            = 10;
  localparam int unsigned GOOD_W           = 7;
  localparam logic [ERR_W-1:0]  MISMATCH_LIMIT = 10'h258;
  localparam logic [ERR_W-1:0]  ERR_MAX        = 10'h3FF;
  localparam logic [GOOD_W-1:0] GOOD_PERIODS   = 7'h7E;
  localparam logic [GOOD_W-1:0] GOOD_MAX       = 7'h7F;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic data;
    logic frameBit;
  } ilbd_line_t;

  typedef struct packed {
    logic [7:0] pattern;
    logic [1:0] lenSel;
  } ilbd_pat_cfg_t;

  typedef enum logic {DET_LOST, DET_FOUND} ilbd_det_state_t;

endpackage : ilbd_pkg

/* File: design/ilbd_code_matcher.sv */
// Purpose: Compares the line against one repeating code and tracks presence.
// Assumes: periodEnd pulses once per period from the shared timer.
// Notes:   A lossy period slips the phase by one bit to hunt alignment.

module ilbd_code_matcher (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire ilbd_pkg::ilbd_line_t    line,
  input  wire ilbd_pkg::ilbd_pat_cfg_t cfg,
  input  wire logic                   framingBitSkip,
  input  wire logic                   periodEnd,
  output logic                        found,
  output logic                        foundChange
);
  import ilbd_pkg::*;

  logic [2:0]        phase;
  logic [ERR_W-1:0]  errCnt;
  logic [GOOD_W-1:0] goodCnt;
  ilbd_det_state_t   state;
  ilbd_det_state_t   next_state;

  // Length select picks the last used pattern bit: 5, 6, 7 or 8 bits.
  wire [2:0] lastPhase  = 3'(3'h4 + {1'b0, cfg.lenSel}); // [R1] [R2]
  wire       expectBit  = cfg.pattern[3'h7 - phase];     // [R7] [R8]
  wire       wrapPhase  = (phase >= lastPhase);          // [R1] [R2]
  wire [2:0] stepPhase  = wrapPhase ? 3'h0 : phase + 3'h1;
  wire       step       = line.valid && !(line.frameBit && framingBitSkip); // [R9]
  wire       countBit   = step && !line.frameBit && (line.data != expectBit); // [R9]
  wire       periodBad  = errCnt > MISMATCH_LIMIT;   // [R3] [R5]
  wire       periodGood = errCnt < MISMATCH_LIMIT;   // [R4] [R6]
  wire       slip       = periodEnd && periodBad;

  // Presence decision at each period boundary.
  always_comb
  begin
    next_state = state;
    if (periodEnd && periodBad)
    begin
      next_state = DET_LOST; // [R3] [R5]
    end
    else if (periodEnd && periodGood && (goodCnt >= GOOD_PERIODS))
    begin
      next_state = DET_FOUND; // [R4] [R6]
    end
  end

  assign found = (state == DET_FOUND);

  // Phase, mismatch count and good-period run, one set per code.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      phase       <= 3'h0;
      errCnt      <= '0;
      goodCnt     <= '0;
      state       <= DET_LOST;
      foundChange <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      foundChange <= (next_state != state);
      if (slip)
      begin
        phase <= step ? phase : stepPhase;
      end
      else if (step)
      begin
        phase <= stepPhase;
      end
      if (periodEnd)
      begin
        errCnt  <= ERR_W'(countBit); // [R13]
        goodCnt <= !periodGood ? '0 : ((goodCnt == GOOD_MAX) ? goodCnt : goodCnt + 1'b1); // [R13]
      end
      else if (errCnt != ERR_MAX)
      begin
        errCnt <= errCnt + ERR_W'(countBit);
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_loss_period: assert property (periodEnd && errCnt > MISMATCH_LIMIT |=> !found && goodCnt == '0) // [R3] [R5]
    else $error("Code not dropped after a lossy period.");
  a_found_period: assert property ($rose(found) |-> $past(periodEnd) && $past(goodCnt) >= GOOD_PERIODS) // [R4] [R6]
    else $error("Code declared without enough good periods.");
  a_fbit_discard: assert property (line.valid && line.frameBit && !periodEnd |=> errCnt == $past(errCnt)) // [R9]
    else $error("Framing bit entered the mismatch count.");
  a_msb_first: assert property (step && !line.frameBit && phase == 3'h0 && line.data != cfg.pattern[7] // [R7] [R8]
    && !periodEnd && errCnt < 10'h3F0 |=> errCnt == $past(errCnt) + 10'h001)
    else $error("First code bit not compared with the top pattern bit.");

endmodule : ilbd_code_matcher

/* File: design/ilbd_inband_loop_detector.sv */
// Purpose: Inband loop-up and loop-down code detector with AXI4-Lite registers.
// Assumes: Received line bits are synchronous to core_clk, one per valid cycle.
// Notes:   Change flags clear by writing one or by reading the flag register.
//
// Operation
// R1 - Loop-up length select sets code length 5,6/3,7,8/4 and used pattern bits.
// R2 - Loop-down length select uses the same encoding on the loop-down pattern.
// R3 - Loop-up found clears when over 600 mismatches occur in one period.
// R4 - Loop-up found sets after over 126 consecutive periods under 600 mismatches.
// R5 - Loop-down found clears when over 600 mismatches occur in one period.
// R6 - Loop-down found sets after over 126 consecutive periods under 600 mismatches.
// R7 - Loop-up pattern bit 7 is compared first; unused low bits ignored.
// R8 - Loop-down pattern bit 7 is compared first; unused low bits ignored.
// R9 - Framing bit compared but discarded when skip is 0, skipped when 1.
// R10 - Each change flag reaches the interrupt only when its enable is 1.
// R11 - Loop-up change flag sets on any found transition; write one clears.
// R12 - Loop-down change flag sets on any found transition; write one clears.
// R13 - Period timed in line bits; mismatch count restarts; runs kept per code.
// R14 - Interrupt stays high while any enabled flag is set, then releases.

module ilbd_inband_loop_detector #(
  parameter int unsigned PERIOD_BITS = ilbd_pkg::PERIOD_BITS_DFLT
) (
  input  wire logic                        core_clk,
  input  wire logic                        resetn,
  // AXI4-Lite slave.
  input  wire logic [ilbd_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [ilbd_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [ilbd_pkg::ADDR_W-1:0] araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [ilbd_pkg::DATA_W-1:0]      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  // Received line and interrupt.
  input  wire ilbd_pkg::ilbd_line_t         rxLine,
  output logic                             irq
);
  import ilbd_pkg::*;

  // ************************************************************
  // Register state
  // ************************************************************
  logic [4:0]        cfgReg;
  logic [7:0]        upPattern;
  logic [7:0]        downPattern;
  logic [1:0]        irqEnable;
  logic [1:0]        flags;
  logic [1:0]        next_flags;
  logic [1:0]        next_irqEnable;

  // Write channel holding state.
  logic              awHeld;
  logic              wHeld;
  logic [ADDR_W-1:0] awAddrHeld;
  logic [7:0]        wByteHeld;
  logic              wLane0Held;

  // Detector outputs.
  logic              periodEnd;
  logic              upFound;
  logic              downFound;
  logic              upChange;
  logic              downChange;

  // ************************************************************
  // Detection datapath
  // ************************************************************

  // Configuration fields feeding the two matchers.
  wire [1:0]     upLenSel       = cfgReg[CFG_UP_SEL_LSB +: 2];
  wire [1:0]     downLenSel     = cfgReg[CFG_DOWN_SEL_LSB +: 2];
  wire           framingBitSkip = cfgReg[CFG_SKIP_BIT];
  ilbd_pat_cfg_t upCfg;
  ilbd_pat_cfg_t downCfg;
  assign upCfg   = '{pattern: upPattern, lenSel: upLenSel};
  assign downCfg = '{pattern: downPattern, lenSel: downLenSel};

  // One period timer shared by both codes.
  ilbd_period_timer #(
    .PERIOD_BITS (PERIOD_BITS)
  ) u_timer (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .line      (rxLine),
    .periodEnd (periodEnd)
  );

  // Loop-up code matcher.
  ilbd_code_matcher u_up (
    .core_clk       (core_clk),
    .resetn         (resetn),
    .line           (rxLine),
    .cfg            (upCfg),
    .framingBitSkip (framingBitSkip),
    .periodEnd      (periodEnd),
    .found          (upFound),
    .foundChange    (upChange)
  );

  // Loop-down code matcher.
  ilbd_code_matcher u_down (
    .core_clk       (core_clk),
    .resetn         (resetn),
    .line           (rxLine),
    .cfg            (downCfg),
    .framingBitSkip (framingBitSkip),
    .periodEnd      (periodEnd),
    .found          (downFound),
    .foundChange    (downChange)
  );

  // ************************************************************
  // AXI4-Lite write path
  // ************************************************************

  // Address and data are taken independently; the write happens once both are held.
  assign awready = !awHeld;
  assign wready  = !wHeld;
  wire awTake  = awvalid && awready;
  wire wTake   = wvalid && wready;
  wire doWrite = awHeld && wHeld && !bvalid;

  // Write address decode.
  wire wrCfg      = doWrite && wLane0Held && (awAddrHeld == ADDR_CONFIG);
  wire wrUpPat    = doWrite && wLane0Held && (awAddrHeld == ADDR_UP_PAT);
  wire wrDownPat  = doWrite && wLane0Held && (awAddrHeld == ADDR_DOWN_PAT);
  wire wrIrqEn    = doWrite && wLane0Held && (awAddrHeld == ADDR_IRQ_EN);
  wire wrFlags    = doWrite && wLane0Held && (awAddrHeld == ADDR_IRQ_FLAGS);
  wire wrMapped   = (awAddrHeld == ADDR_CONFIG) || (awAddrHeld == ADDR_STATUS) ||
                    (awAddrHeld == ADDR_UP_PAT) || (awAddrHeld == ADDR_DOWN_PAT) ||
                    (awAddrHeld == ADDR_IRQ_EN) || (awAddrHeld == ADDR_IRQ_FLAGS);
  wire [1:0] w1cMask = wrFlags ? {wByteHeld[UP_BIT], wByteHeld[DOWN_BIT]} : 2'h0;

  // Channel capture and write response.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      awHeld     <= 1'b0;
      wHeld      <= 1'b0;
      awAddrHeld <= '0;
      wByteHeld  <= 8'h00;
      wLane0Held <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
    end
    else
    begin
      if (awTake)
      begin
        awHeld     <= 1'b1;
        awAddrHeld <= awaddr;
      end
      else if (doWrite)
      begin
        awHeld <= 1'b0;
      end
      if (wTake)
      begin
        wHeld      <= 1'b1;
        wByteHeld  <= wdata[7:0];
        wLane0Held <= wstrb[0];
      end
      else if (doWrite)
      begin
        wHeld <= 1'b0;
      end
      if (doWrite)
      begin
        bvalid <= 1'b1;
        bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
      begin
        bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read path
  // ************************************************************

  // Read address decode and data selection.
  assign arready = !rvalid;
  wire       arTake    = arvalid && arready;
  wire       rdFlags   = arTake && (araddr == ADDR_IRQ_FLAGS);
  wire [7:0] statusVal = 8'({upFound, downFound});
  wire [7:0] flagsVal  = 8'(flags);
  wire       rdMapped  = (araddr == ADDR_CONFIG) || (araddr == ADDR_STATUS) ||
                         (araddr == ADDR_UP_PAT) || (araddr == ADDR_DOWN_PAT) ||
                         (araddr == ADDR_IRQ_EN) || (araddr == ADDR_IRQ_FLAGS);
  wire [7:0] rdByte    = (araddr == ADDR_CONFIG)   ? 8'(cfgReg) :
                         (araddr == ADDR_STATUS)   ? statusVal :
                         (araddr == ADDR_UP_PAT)   ? upPattern :
                         (araddr == ADDR_DOWN_PAT) ? downPattern :
                         (araddr == ADDR_IRQ_EN)   ? 8'(irqEnable) :
                         (araddr == ADDR_IRQ_FLAGS) ? flagsVal : 8'h00;

  // Read data is captured when the address is taken.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end
    else if (arTake)
    begin
      rvalid <= 1'b1;
      rdata  <= DATA_W'(rdByte);
      rresp  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
    begin
      rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Control registers, flags and interrupt
  // ************************************************************

  // A change sets its flag even in the cycle of a clear; reads of the flag register clear all flags.
  assign next_flags[UP_BIT]   = upChange ||                                          // [R11]
                                (flags[UP_BIT] && !w1cMask[UP_BIT] && !rdFlags);       // [R11]
  assign next_flags[DOWN_BIT] = downChange ||                                        // [R12]
                                (flags[DOWN_BIT] && !w1cMask[DOWN_BIT] && !rdFlags);   // [R12]
  assign next_irqEnable = wrIrqEn ? {wByteHeld[UP_BIT], wByteHeld[DOWN_BIT]} : irqEnable;

  // Software registers and the registered interrupt level.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfgReg      <= CONFIG_RST;
      upPattern   <= UP_PAT_RST;
      downPattern <= DOWN_PAT_RST;
      irqEnable   <= IRQ_EN_RST;
      flags       <= FLAGS_RST;
      irq         <= 1'b0;
    end
    else
    begin
      flags     <= next_flags;
      irqEnable <= next_irqEnable;
      irq       <= |(next_flags & next_irqEnable); // [R10] [R14]
      if (wrCfg)
      begin
        cfgReg <= wByteHeld[4:0]; // [R1] [R2] [R9]
      end
      if (wrUpPat)
      begin
        upPattern <= wByteHeld;
      end
      if (wrDownPat)
      begin
        downPattern <= wByteHeld;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_irq_gating: assert property (irq == |(flags & irqEnable)) // [R10] [R14]
    else $error("Interrupt level disagrees with enabled flags.");
  a_up_change_edge: assert property (upChange == $changed(upFound)) // [R11]
    else $error("Loop-up change pulse not tied to a found transition.");
  a_down_change_edge: assert property (downChange == $changed(downFound)) // [R12]
    else $error("Loop-down change pulse not tied to a found transition.");
  a_up_flag_set: assert property (upChange |=> flags[UP_BIT]) // [R11]
    else $error("Loop-up change flag missed an event.");
  a_down_flag_set: assert property (downChange |=> flags[DOWN_BIT]) // [R12]
    else $error("Loop-down change flag missed an event.");
  a_w1c_clear: assert property (wrFlags && wByteHeld[UP_BIT] && !upChange |=> !flags[UP_BIT]) // [R11]
    else $error("Writing one did not clear the loop-up flag.");
  a_cfg_write: assert property (wrCfg |=> framingBitSkip == $past(wByteHeld[CFG_SKIP_BIT]) // [R1] [R2] [R9]
    && upLenSel == $past(wByteHeld[1:0]) && downLenSel == $past(wByteHeld[3:2]))
    else $error("Configuration write not applied.");
  a_irq_masked: assert property (irqEnable == 2'h0 |-> !irq ##1 1'b1) // [R10]
    else $error("Interrupt raised with all enables off.");
  a_write_resp: assert property (doWrite |=> bvalid ##0 (bresp == RESP_OKAY || bresp == RESP_SLVERR))
    else $error("Write not answered one cycle after it happened.");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("Read answer changed before it was taken.");

  c_up_found: cover property ($rose(upFound));
  c_down_found: cover property ($rose(downFound));
  c_irq_raised: cover property ($rose(irq));
  c_flag_w1c: cover property (wrFlags && flags[UP_BIT] ##1 !flags[UP_BIT]);

endmodule : ilbd_inband_loop_detector

/* File: design/ilbd_period_timer.sv */
// Purpose: Marks the end of each fixed measurement period.
// Assumes: One line bit per cycle at most, flagged by valid.
// Notes:   The end pulse comes one cycle after the period's last bit.

module ilbd_period_timer #(
  parameter int unsigned PERIOD_BITS = ilbd_pkg::PERIOD_BITS_DFLT
) (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire ilbd_pkg::ilbd_line_t line,
  output logic                     periodEnd
);
  import ilbd_pkg::*;

  localparam int unsigned     CW   = $clog2(PERIOD_BITS);
  localparam logic [CW-1:0]   LAST = CW'(PERIOD_BITS - 1);

  logic [CW-1:0] bitCount;
  wire           atLast = line.valid && (bitCount == LAST);

  // Count received line bits and wrap at the period length.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bitCount  <= '0;
      periodEnd <= 1'b0;
    end
    else
    begin
      periodEnd <= atLast; // [R13]
      if (line.valid)
      begin
        bitCount <= atLast ? '0 : bitCount + 1'b1; // [R13]
      end
    end
  end

endmodule : ilbd_period_timer

/* File: test/ilbd_inband_loop_detector_test.sv */
// Purpose: Self-checking bench of the inband loop code detector.
// Assumes: A short period of 700 line bits keeps the run brief.
// Notes:   Both codes are set to one 5-bit value so both detect together.

module ilbd_inband_loop_detector_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ilbd_pkg::*;

  // ************************************************************
  // Signals, clock and instances
  // ************************************************************
  localparam int unsigned P = 700;
  logic              core_clk, resetn, run, corrupt, irq;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  ilbd_line_t        rxLine;
  int                fail_count, comparisons;

  // Free-running core clock.
  always #5 core_clk = ~core_clk;

  ilbd_inband_loop_detector #(.PERIOD_BITS(P)) u_dut (.core_clk, .resetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .rxLine, .irq);
  ilbd_line_source u_src (.core_clk, .resetn, .run, .corrupt, .code(8'hA8), .codeLen(4'h5), .rxLine);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // Writes one byte; each channel is held until its own ready.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [2:0] pend;
    logic [2:0] t;
    int         n;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pend = 3'h7;
    for (n = 0; n < 50 && pend != 0; n++)
    begin
      @(negedge core_clk);
      t = pend & {awready, wready, bvalid};
      if (t[0]) check(32'(bresp), 32'(RESP_OKAY));
      @(posedge core_clk);
      awvalid <= pend[2] & ~t[2];
      wvalid <= pend[1] & ~t[1];
      bready <= pend[0] & ~t[0];
      pend = pend & ~t;
    end
    if (pend != 0)
    begin
      fail_count++;
      wrap_up();
    end
  endtask : wr

  // Reads one register and compares data and response.
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] ed, input logic [1:0] er);
    logic [1:0] pend;
    logic [1:0] t;
    int         n;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    pend = 2'h3;
    for (n = 0; n < 50 && pend != 0; n++)
    begin
      @(negedge core_clk);
      t = pend & {arready, rvalid};
      if (t[0]) check(rdata, {24'h0, ed});
      if (t[0]) check(32'(rresp), 32'(er));
      @(posedge core_clk);
      arvalid <= pend[1] & ~t[1];
      rready <= pend[0] & ~t[0];
      pend = pend & ~t;
    end
    if (pend != 0)
    begin
      fail_count++;
      wrap_up();
    end
  endtask : rd_chk

  // Waits for the interrupt under a bound.
  task automatic wait_irq(input int lim);
    int n;
    for (n = 0; n < lim && irq !== 1'b1; n++)
      @(negedge core_clk);
    if (n == lim)
    begin
      fail_count++;
      wrap_up();
    end
  endtask : wait_irq

  task automatic irq_is(input logic e);
    @(negedge core_clk);
    check({31'h0, irq}, {31'h0, e});
  endtask : irq_is

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    rd_chk(ADDR_CONFIG, 8'h04, RESP_OKAY);
    rd_chk(ADDR_STATUS, 8'h00, RESP_OKAY);
    rd_chk(ADDR_UP_PAT, 8'h08, RESP_OKAY);
    rd_chk(ADDR_DOWN_PAT, 8'h24, RESP_OKAY);
    rd_chk(ADDR_IRQ_EN, 8'h00, RESP_OKAY);
    rd_chk(ADDR_IRQ_FLAGS, 8'h00, RESP_OKAY);
    wr(ADDR_STATUS, 8'hFF);
    rd_chk(ADDR_STATUS, 8'h00, RESP_OKAY);
    rd_chk(12'h000, 8'h00, RESP_SLVERR);
  endtask : t_reset

  // Five-bit codes; low pattern bits hold junk that must be ignored.
  task automatic t_regs;
    wr(ADDR_CONFIG, 8'hFF);
    rd_chk(ADDR_CONFIG, 8'h1F, RESP_OKAY);
    wr(ADDR_CONFIG, 8'h00);
    wr(ADDR_UP_PAT, 8'hAF);
    wr(ADDR_DOWN_PAT, 8'hAB);
    wr(ADDR_IRQ_EN, 8'h03);
    rd_chk(ADDR_UP_PAT, 8'hAF, RESP_OKAY);
    rd_chk(ADDR_DOWN_PAT, 8'hAB, RESP_OKAY);
    rd_chk(ADDR_IRQ_EN, 8'h03, RESP_OKAY);
  endtask : t_regs

  task automatic t_found;
    @(posedge core_clk);
    run <= 1'b1;
    repeat (126 * P) @(posedge core_clk);
    rd_chk(ADDR_STATUS, 8'h00, RESP_OKAY);
    wait_irq(3 * P);
    rd_chk(ADDR_STATUS, 8'h03, RESP_OKAY);
  endtask : t_found

  task automatic t_masks;
    wr(ADDR_IRQ_EN, 8'h01);
    irq_is(1'b1);
    wr(ADDR_IRQ_FLAGS, 8'h01);
    irq_is(1'b0);
    rd_chk(ADDR_IRQ_FLAGS, 8'h02, RESP_OKAY);
    rd_chk(ADDR_IRQ_FLAGS, 8'h00, RESP_OKAY);
  endtask : t_masks

  task automatic t_loss;
    wr(ADDR_IRQ_EN, 8'h02);
    @(posedge core_clk);
    corrupt <= 1'b1;
    wait_irq(3 * P);
    rd_chk(ADDR_STATUS, 8'h00, RESP_OKAY);
    rd_chk(ADDR_IRQ_FLAGS, 8'h03, RESP_OKAY);
    irq_is(1'b0);
  endtask : t_loss

  // Main sequence.
  initial
  begin
    core_clk = 1'b0;
    resetn = 1'b0;
    {run, corrupt, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    fail_count = 0;
    comparisons = 0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_regs();
    t_found();
    t_masks();
    t_loss();
    wrap_up();
  end
endmodule : ilbd_inband_loop_detector_test

/* File: test/ilbd_line_source.sv */
// Purpose: Far-end model that sends a repeating loop code on the line.
// Assumes: One line bit per core_clk cycle while run is high.
// Notes:   Every 193rd bit is a framing bit and advances the code phase.

module ilbd_line_source (
  input  wire logic            core_clk,
  input  wire logic            resetn,
  input  wire logic            run,
  input  wire logic            corrupt,
  input  wire logic [7:0]      code,
  input  wire logic [3:0]      codeLen,
  output ilbd_pkg::ilbd_line_t rxLine
);
  import ilbd_pkg::*;

  int unsigned bitNum;
  int unsigned phase;

  // Sends the code MSB first; corrupt inverts every bit so a period is lost.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bitNum <= 0;
      phase  <= 0;
      rxLine <= '0;
    end
    else if (run)
    begin
      rxLine.valid    <= 1'b1;
      rxLine.frameBit <= (bitNum % 193 == 0);
      rxLine.data     <= code[3'(7 - phase)] ^ corrupt;
      phase           <= (phase + 1 == codeLen) ? 0 : phase + 1;
      bitNum          <= bitNum + 1;
    end
    else
    begin
      rxLine.valid <= 1'b0;
      rxLine.data  <= ~rxLine.data; // Idle data keeps toggling so no stale bit is trusted.
    end
  end
endmodule : ilbd_line_source
